// [logic/bdgr_bus_if.sv]
/*
  Register access carrier between the serial front end and the register
  bank. Assumes both ends run on the one system clock.
*/
`timescale 1ns/100ps
interface bdgr_bus_if;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport master (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport slave (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// [logic/bdgr_params.svh]
/*
  Offsets, field positions, reset values, codes and timing counts of the
  burnout, converter code and pin A register slice. Assumes the includer
  uses these with 7-bit register addresses and 16-bit register data.
*/
`ifndef BDGR_PARAMS_SVH
`define BDGR_PARAMS_SVH

// register offsets
`define BDGR_ADDR_BURNOUT 7'h0a
`define BDGR_ADDR_CODE 7'h0b
`define BDGR_ADDR_ACTIVE 7'h0d
`define BDGR_ADDR_PIN_A 7'h35

// reset values and writable masks
`define BDGR_RST_BURNOUT 16'h0000
`define BDGR_RST_CODE 16'h0000
`define BDGR_RST_PIN_A 16'h0008
`define BDGR_WMASK_BURNOUT 16'h7fff
`define BDGR_WMASK_CODE 16'h3fff
`define BDGR_WMASK_PIN_A 16'h001f

// burnout field positions
`define BDGR_S2_MAG_HI 14
`define BDGR_S2_MAG_LO 12
`define BDGR_S2_POL 11
`define BDGR_S2_EN 10
`define BDGR_S1_MAG_HI 9
`define BDGR_S1_MAG_LO 7
`define BDGR_S1_POL 6
`define BDGR_S1_EN 5
`define BDGR_T_MAG_HI 4
`define BDGR_T_MAG_LO 2
`define BDGR_T_POL 1
`define BDGR_T_EN 0

// burnout magnitude codes
`define BDGR_MAG_OFF 3'h0
`define BDGR_MAG_50NA 3'h1
`define BDGR_MAG_500NA 3'h3
`define BDGR_MAG_1UA 3'h4
`define BDGR_MAG_10UA 3'h6

// pin A field positions and mode codes
`define BDGR_PIN_MODE_HI 2
`define BDGR_PIN_MODE_LO 0
`define BDGR_PIN_PULLDOWN 3
`define BDGR_PIN_LEVEL 4
`define BDGR_PIN_READBACK 5
`define BDGR_MODE_HIZ 3'h0
`define BDGR_MODE_OUT 3'h1
`define BDGR_MODE_OUTIN 3'h2
`define BDGR_MODE_IN 3'h3
`define BDGR_MODE_COMP 3'h4

// serial frame: read flag, 7 address bits, 16 data bits
`define BDGR_FRAME_HDR_LAST 5'h07
`define BDGR_FRAME_LAST 5'h17

// timing: slew step period
`define BDGR_CLK_MHZ 25
`define BDGR_SLEW_TICK_NS 1000
`define BDGR_SLEW_TICK_CYC ((`BDGR_SLEW_TICK_NS * `BDGR_CLK_MHZ) / 1000)

`endif

// [logic/bdgr_pkg.sv]
/*
  Types shared by the register slice and its serial front end.
  Assumes nothing of its surroundings.
*/
package bdgr_pkg;
  // decoded burnout current level handed to the analog side
  typedef enum logic [2:0] {
    BDGR_CUR_OFF, BDGR_CUR_50NA, BDGR_CUR_500NA, BDGR_CUR_1UA, BDGR_CUR_10UA
  } bdgr_current_e;
  // decoded pin A mode
  typedef enum logic [2:0] {
    BDGR_PIN_HIZ, BDGR_PIN_OUT, BDGR_PIN_OUTIN, BDGR_PIN_IN, BDGR_PIN_COMP
  } bdgr_pin_mode_e;
  // serial frame phase
  typedef enum logic [1:0] {
    BDGR_SPI_HDR, BDGR_SPI_DATA, BDGR_SPI_DONE
  } bdgr_spi_state_e;
endpackage

// [logic/bdgr_regs.sv]
/*
  Burnout current, converter code, active code and pin A configuration
  registers behind the serial register port. Assumes the analog side takes
  the decoded burnout levels and the active converter code as levels, and
  that the pin pad resolves the level from pin_a_o and pin_a_oe_o.
*/
`timescale 1ns/100ps
`include "bdgr_params.svh"
module bdgr_regs #(
  parameter int SLEW_TICK_CYC = `BDGR_SLEW_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial register port
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // slew control from the output function logic
  input wire logic slew_enable_i,
  input wire logic [13:0] slew_step_i,
  // converter
  output logic [13:0] converter_code_o,
  // burnout controls
  output bdgr_pkg::bdgr_current_e terminal_burnout_level_o,
  output logic terminal_burnout_polarity_o,
  output logic terminal_burnout_enable_o,
  output bdgr_pkg::bdgr_current_e sense1_burnout_level_o,
  output logic sense1_burnout_polarity_o,
  output logic sense1_burnout_enable_o,
  output bdgr_pkg::bdgr_current_e sense2_burnout_level_o,
  output logic sense2_burnout_polarity_o,
  output logic sense2_burnout_enable_o,
  // pin A and comparator
  input wire logic pin_a_i,
  input wire logic comparator_i,
  output logic pin_a_o,
  output logic pin_a_oe_o,
  output logic pin_a_pulldown_o
);
  bdgr_bus_if bus ();

  logic [15:0] burnout_q;
  logic [15:0] code_q;
  logic [13:0] active_q;
  logic [15:0] pin_cfg_q;
  logic [1:0] pin_s_q;
  logic [1:0] comp_s_q;
  logic readback_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic [14:0] step_eff;
  logic [14:0] diff_up;
  logic [14:0] diff_dn;
  logic [15:0] rdata;
  bdgr_pkg::bdgr_pin_mode_e mode;
  bdgr_pkg::bdgr_current_e t_lvl_q;
  bdgr_pkg::bdgr_current_e s1_lvl_q;
  bdgr_pkg::bdgr_current_e s2_lvl_q;

  // merge writable bits only, so reserved bits never take a write
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [15:0] mask);
    wmerge = (old & ~mask) | (wd & mask);
  endfunction

  // magnitude decode; reserved codes give no current
  function automatic bdgr_pkg::bdgr_current_e cur_decode(input logic [2:0] mag,
                                                         input logic sense);
    case (mag)
      `BDGR_MAG_50NA: cur_decode = sense ? bdgr_pkg::BDGR_CUR_50NA : bdgr_pkg::BDGR_CUR_OFF;
      `BDGR_MAG_500NA: cur_decode = sense ? bdgr_pkg::BDGR_CUR_500NA : bdgr_pkg::BDGR_CUR_OFF;
      `BDGR_MAG_1UA: cur_decode = bdgr_pkg::BDGR_CUR_1UA;
      `BDGR_MAG_10UA: cur_decode = bdgr_pkg::BDGR_CUR_10UA;
      default: cur_decode = bdgr_pkg::BDGR_CUR_OFF;
    endcase
  endfunction

  // serial front end
  bdgr_spi_slave u_spi (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe_o(spi_miso_oe_o),
    .bus(bus.master)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      burnout_q <= `BDGR_RST_BURNOUT;
    end else if (bus.wr_stb && bus.addr == `BDGR_ADDR_BURNOUT) begin
      burnout_q <= wmerge(burnout_q, bus.wdata, `BDGR_WMASK_BURNOUT);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      t_lvl_q <= bdgr_pkg::BDGR_CUR_OFF;
      s1_lvl_q <= bdgr_pkg::BDGR_CUR_OFF;
      s2_lvl_q <= bdgr_pkg::BDGR_CUR_OFF;
    end else begin
      t_lvl_q <= cur_decode(burnout_q[`BDGR_T_MAG_HI:`BDGR_T_MAG_LO], 1'b0);
      s1_lvl_q <= cur_decode(burnout_q[`BDGR_S1_MAG_HI:`BDGR_S1_MAG_LO], 1'b1);
      s2_lvl_q <= cur_decode(burnout_q[`BDGR_S2_MAG_HI:`BDGR_S2_MAG_LO], 1'b1);
    end
  end

  assign terminal_burnout_level_o = t_lvl_q;
  assign sense1_burnout_level_o = s1_lvl_q;
  assign sense2_burnout_level_o = s2_lvl_q;
  assign terminal_burnout_polarity_o = burnout_q[`BDGR_T_POL];
  assign terminal_burnout_enable_o = burnout_q[`BDGR_T_EN];
  assign sense1_burnout_polarity_o = burnout_q[`BDGR_S1_POL];
  assign sense1_burnout_enable_o = burnout_q[`BDGR_S1_EN];
  assign sense2_burnout_polarity_o = burnout_q[`BDGR_S2_POL];
  assign sense2_burnout_enable_o = burnout_q[`BDGR_S2_EN];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      code_q <= `BDGR_RST_CODE;
    end else if (bus.wr_stb && bus.addr == `BDGR_ADDR_CODE) begin
      code_q <= wmerge(code_q, bus.wdata, `BDGR_WMASK_CODE);
    end
  end

  // slew step divider; the tick is a one-cycle enable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign tick = tick_cnt_q >= 16'(SLEW_TICK_CYC - 1);
  assign step_eff = (slew_step_i == 14'h0000) ? 15'h0001 : {1'b0, slew_step_i};
  assign diff_up = {1'b0, code_q[13:0]} - {1'b0, active_q};
  assign diff_dn = {1'b0, active_q} - {1'b0, code_q[13:0]};

  // active code walks one step per tick
  // a step of zero would stall forever, so it counts as one
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      active_q <= 14'h0000;
    end else if (!slew_enable_i) begin
      active_q <= code_q[13:0];
    end else if (tick && code_q[13:0] > active_q) begin
      active_q <= (diff_up > step_eff) ? 14'(active_q + step_eff[13:0]) : code_q[13:0];
    end else if (tick && code_q[13:0] < active_q) begin
      active_q <= (diff_dn > step_eff) ? 14'(active_q - step_eff[13:0]) : code_q[13:0];
    end
  end

  assign converter_code_o = active_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_cfg_q <= `BDGR_RST_PIN_A;
    end else if (bus.wr_stb && bus.addr == `BDGR_ADDR_PIN_A) begin
      pin_cfg_q <= wmerge(pin_cfg_q, bus.wdata, `BDGR_WMASK_PIN_A);
    end
  end

  assign pin_a_pulldown_o = pin_cfg_q[`BDGR_PIN_PULLDOWN];

  // unlisted modes fall to high impedance
  always_comb begin
    case (pin_cfg_q[`BDGR_PIN_MODE_HI:`BDGR_PIN_MODE_LO])
      `BDGR_MODE_OUT: mode = bdgr_pkg::BDGR_PIN_OUT;
      `BDGR_MODE_OUTIN: mode = bdgr_pkg::BDGR_PIN_OUTIN;
      `BDGR_MODE_IN: mode = bdgr_pkg::BDGR_PIN_IN;
      `BDGR_MODE_COMP: mode = bdgr_pkg::BDGR_PIN_COMP;
      default: mode = bdgr_pkg::BDGR_PIN_HIZ;
    endcase
  end

  // pin and comparator synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s_q <= 2'h0;
      comp_s_q <= 2'h0;
    end else begin
      pin_s_q <= {pin_s_q[0], pin_a_i};
      comp_s_q <= {comp_s_q[0], comparator_i};
    end
  end

  // drive level from the level bit, or from the synchronised comparator in comparator mode
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_a_o <= 1'b0;
      pin_a_oe_o <= 1'b0;
    end else begin
      case (mode)
        bdgr_pkg::BDGR_PIN_OUT, bdgr_pkg::BDGR_PIN_OUTIN: begin
          pin_a_o <= pin_cfg_q[`BDGR_PIN_LEVEL];
          pin_a_oe_o <= 1'b1;
        end
        bdgr_pkg::BDGR_PIN_COMP: begin
          pin_a_o <= comp_s_q[1];
          pin_a_oe_o <= 1'b1;
        end
        default: begin
          pin_a_o <= 1'b0;
          pin_a_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // readback through the input buffer
  // a disabled buffer reads as zero rather than a floating pad
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      readback_q <= 1'b0;
    end else begin
      readback_q <= (mode == bdgr_pkg::BDGR_PIN_OUTIN || mode == bdgr_pkg::BDGR_PIN_IN)
                    && pin_s_q[1];
    end
  end

  always_comb begin
    case (bus.addr)
      `BDGR_ADDR_BURNOUT: rdata = burnout_q & `BDGR_WMASK_BURNOUT;
      `BDGR_ADDR_CODE: rdata = code_q & `BDGR_WMASK_CODE;
      `BDGR_ADDR_ACTIVE: rdata = {2'h0, active_q};
      `BDGR_ADDR_PIN_A: rdata = {10'h000, readback_q, pin_cfg_q[4:0]};
      default: rdata = 16'h0000;
    endcase
  end

  assign bus.rdata = rdata;

  // mode held for several cycles, so synchroniser latency has settled
  sequence s_in_held;
    (mode == bdgr_pkg::BDGR_PIN_IN || mode == bdgr_pkg::BDGR_PIN_OUTIN) [*3];
  endsequence

  property p_burnout_reset;
    @(posedge clk_sys_i) rst_i |=> burnout_q == 16'h0000;
  endproperty
  a_burnout_reset: assert property (p_burnout_reset) else $error("burnout not cleared");

  property p_sense_decode;
    @(posedge clk_sys_i) disable iff (rst_i)
      burnout_q[9:7] == 3'h6 && $stable(burnout_q) |=> s1_lvl_q == bdgr_pkg::BDGR_CUR_10UA;
  endproperty
  a_sense_decode: assert property (p_sense_decode) else $error("sense decode wrong");

  property p_term_reserved;
    @(posedge clk_sys_i) disable iff (rst_i)
      burnout_q[4:2] == 3'h3 |=> t_lvl_q == bdgr_pkg::BDGR_CUR_OFF;
  endproperty
  a_term_reserved: assert property (p_term_reserved) else $error("terminal accepts 500nA");

  property p_code_write;
    @(posedge clk_sys_i) disable iff (rst_i)
      bus.wr_stb && bus.addr == 7'h0b |=> code_q == {2'h0, $past(bus.wdata[13:0])};
  endproperty
  a_code_write: assert property (p_code_write) else $error("code write lost");

  property p_code_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(bus.wr_stb && bus.addr == 7'h0b) |=> $stable(code_q);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed unasked");

  property p_active_read;
    @(posedge clk_sys_i) disable iff (rst_i)
      bus.addr == 7'h0d |-> bus.rdata == {2'h0, active_q};
  endproperty
  a_active_read: assert property (p_active_read) else $error("active readback wrong");

  property p_slew_step;
    @(posedge clk_sys_i) disable iff (rst_i)
      slew_enable_i && tick && code_q[13:0] > active_q && diff_up > step_eff
      |=> active_q != code_q[13:0] && active_q == $past(active_q) + $past(step_eff[13:0]);
  endproperty
  a_slew_step: assert property (p_slew_step) else $error("slew jumped");

  property p_pulldown_reset;
    @(posedge clk_sys_i) rst_i |=> pin_a_pulldown_o && pin_cfg_q == `BDGR_RST_PIN_A;
  endproperty
  a_pulldown_reset: assert property (p_pulldown_reset) else $error("pull-down off at reset");

  property p_readback;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_in_held |=> readback_q == $past(pin_s_q[1]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_out_drive;
    @(posedge clk_sys_i) disable iff (rst_i)
      mode == bdgr_pkg::BDGR_PIN_OUT |=> pin_a_oe_o && pin_a_o == $past(pin_cfg_q[4]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output level wrong");

  property p_hiz;
    @(posedge clk_sys_i) disable iff (rst_i)
      pin_cfg_q[2:0] == 3'h0 || pin_cfg_q[2:0] > 3'h4 |=> !pin_a_oe_o && !readback_q;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz mode drives");

  property p_input_mode;
    @(posedge clk_sys_i) disable iff (rst_i)
      mode == bdgr_pkg::BDGR_PIN_IN |=> !pin_a_oe_o;
  endproperty
  a_input_mode: assert property (p_input_mode) else $error("input mode drives");

  property p_comp_mode;
    @(posedge clk_sys_i) disable iff (rst_i)
      mode == bdgr_pkg::BDGR_PIN_COMP |=> pin_a_oe_o && pin_a_o == $past(comp_s_q[1]);
  endproperty
  a_comp_mode: assert property (p_comp_mode) else $error("comparator not driven");

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      bus.addr == 7'h35 |-> bus.rdata[15:6] == 10'h000 && burnout_q[15] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
endmodule // bdgr_regs

// [logic/bdgr_spi_slave.sv]
/*
  Serial register port, mode 0, MSB first, 24-bit frame: read flag, address,
  data. Assumes the serial clock is slower than a quarter of clk_sys_i per
  half period, since all pins are oversampled through synchronisers.
*/
`timescale 1ns/100ps
`include "bdgr_params.svh"
module bdgr_spi_slave (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial pins
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // register access
  bdgr_bus_if.master bus
);
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] mosi_s_q;
  logic sclk_last_q;
  logic [4:0] cnt_q;
  logic [22:0] shin_q;
  logic [15:0] tx_q;
  logic rw_q;
  logic rd_stb_q;
  logic wr_stb_q;
  logic [6:0] addr_q;
  logic [15:0] wdata_q;
  logic miso_q;
  bdgr_pkg::bdgr_spi_state_e state_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;

  // two-flop synchronisers; only the second stage is read by logic
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sclk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      sclk_last_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], spi_sclk_i};
      cs_s_q <= {cs_s_q[0], spi_cs_n_i};
      mosi_s_q <= {mosi_s_q[0], spi_mosi_i};
      sclk_last_q <= sclk_s_q[1];
    end
  end

  // edges seen on the synchronised clock
  assign sclk_rise = sclk_s_q[1] & ~sclk_last_q;
  assign sclk_fall = ~sclk_s_q[1] & sclk_last_q;
  assign cs_act = ~cs_s_q[1];

  // frame sequencing; a frame cut short by select never writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !cs_act) begin
      state_q <= bdgr_pkg::BDGR_SPI_HDR;
      cnt_q <= 5'h00;
      shin_q <= 23'h00_0000;
      rw_q <= 1'b0;
      addr_q <= 7'h00;
    end else if (sclk_rise && state_q != bdgr_pkg::BDGR_SPI_DONE) begin
      shin_q <= {shin_q[21:0], mosi_s_q[1]};
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == `BDGR_FRAME_HDR_LAST) begin
        state_q <= bdgr_pkg::BDGR_SPI_DATA;
        rw_q <= shin_q[6];
        addr_q <= {shin_q[5:0], mosi_s_q[1]};
      end
      if (cnt_q == `BDGR_FRAME_LAST) begin
        state_q <= bdgr_pkg::BDGR_SPI_DONE;
      end
    end
  end

  // access strobes, one cycle each
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wdata_q <= 16'h0000;
    end else begin
      rd_stb_q <= cs_act && sclk_rise && state_q == bdgr_pkg::BDGR_SPI_HDR
                  && cnt_q == `BDGR_FRAME_HDR_LAST && shin_q[6];
      wr_stb_q <= cs_act && sclk_rise && state_q == bdgr_pkg::BDGR_SPI_DATA
                  && cnt_q == `BDGR_FRAME_LAST && !rw_q;
      if (cs_act && sclk_rise && cnt_q == `BDGR_FRAME_LAST) begin
        wdata_q <= {shin_q[14:0], mosi_s_q[1]};
      end
    end
  end

  // read data shifts out on falling edges, first bit after the header
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_q <= 16'h0000;
      miso_q <= 1'b0;
    end else if (rd_stb_q) begin
      tx_q <= bus.rdata;
    end else if (cs_act && sclk_fall && state_q == bdgr_pkg::BDGR_SPI_DATA) begin
      miso_q <= tx_q[15];
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign spi_miso_o = miso_q;
  assign spi_miso_oe_o = cs_act && rw_q && state_q != bdgr_pkg::BDGR_SPI_HDR;
  assign bus.rd_stb = rd_stb_q;
  assign bus.wr_stb = wr_stb_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
endmodule // bdgr_spi_slave

// [tb/bdgr_host_model.sv]
/*
  Host model for the serial register port. It sends mode 0 frames of 24 bits.
  Assumes clk_sys_i is the block clock. Each sclk phase lasts 6 of its cycles.
*/
`timescale 1ns/100ps
module bdgr_host_model (
  // clock
  input wire logic clk_sys_i,
  // serial pins
  input wire logic spi_miso_i,
  output logic spi_sclk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o
);
  // idle state: the clock stands still and select is high
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // one frame: 6 cycles per phase keeps clear of the 4-cycle synchroniser floor
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
                      output logic [15:0] rdata);
    logic [23:0] f;
    f = {rd, addr, wd};
    rdata = 16'h0000;
    @(negedge clk_sys_i) spi_cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_mosi_o = f[i];
      repeat (6) @(negedge clk_sys_i);
      spi_sclk_o = 1'b1;
      rdata = {rdata[14:0], spi_miso_i};
      repeat (6) @(negedge clk_sys_i);
      spi_sclk_o = 1'b0;
    end
    repeat (6) @(negedge clk_sys_i);
    spi_cs_n_o = 1'b1;
    // a released data line must not keep showing its last bit
    spi_mosi_o = ~spi_mosi_o;
    repeat (6) @(negedge clk_sys_i);
  endtask
endmodule // bdgr_host_model

// [tb/bdgr_regs_tb_top.sv]
/*
  Self-checking bench for the burnout, code and pin A registers.
  Assumes bdgr_regs runs with a short slew tick and has the host model on its pins.
*/
`timescale 1ns/100ps
`include "bdgr_params.svh"
module bdgr_regs_tb_top;
  logic clk_sys_i, rst_i, slew_enable_i, comparator_i, ext_lvl, pin_w, miso_w;
  logic sclk, cs_n, mosi, miso, miso_oe, pin_o, pin_oe, pd, s2p, s2e, s1p, s1e, tp, te;
  logic [13:0] slew_step_i, code_o;
  bdgr_pkg::bdgr_current_e lv_t, lv_1, lv_2;
  int num_errors = 0;
  int n_tests = 0;
  // the pad follows the driver when it is enabled, the outside level otherwise
  assign pin_w = pin_oe ? pin_o : ext_lvl;
  assign miso_w = miso_oe ? miso : ~miso;
  bdgr_host_model u_bdgr_host_model (.clk_sys_i(clk_sys_i), .spi_miso_i(miso_w),
    .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));
  bdgr_regs #(.SLEW_TICK_CYC(2)) u_bdgr_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .slew_enable_i(slew_enable_i), .slew_step_i(slew_step_i),
    .converter_code_o(code_o), .terminal_burnout_level_o(lv_t),
    .terminal_burnout_polarity_o(tp), .terminal_burnout_enable_o(te),
    .sense1_burnout_level_o(lv_1), .sense1_burnout_polarity_o(s1p),
    .sense1_burnout_enable_o(s1e), .sense2_burnout_level_o(lv_2),
    .sense2_burnout_polarity_o(s2p), .sense2_burnout_enable_o(s2e), .pin_a_i(pin_w),
    .comparator_i(comparator_i), .pin_a_o(pin_o), .pin_a_oe_o(pin_oe),
    .pin_a_pulldown_o(pd));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_bdgr_host_model.xfer(1'b1, a, 16'h0000, d);
    chk(what, exp, d);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_bdgr_host_model.xfer(1'b0, a, d, x);
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // expected level; the terminal pin has no 50 nA or 500 nA setting
  function automatic logic [15:0] lvl(input logic [2:0] c, input logic term);
    case (c)
      3'h1: lvl = term ? 16'(bdgr_pkg::BDGR_CUR_OFF) : 16'(bdgr_pkg::BDGR_CUR_50NA);
      3'h3: lvl = term ? 16'(bdgr_pkg::BDGR_CUR_OFF) : 16'(bdgr_pkg::BDGR_CUR_500NA);
      3'h4: lvl = 16'(bdgr_pkg::BDGR_CUR_1UA);
      3'h6: lvl = 16'(bdgr_pkg::BDGR_CUR_10UA);
      default: lvl = 16'(bdgr_pkg::BDGR_CUR_OFF);
    endcase
  endfunction
  task automatic t_reset;
    rd_chk("burnout", `BDGR_ADDR_BURNOUT, 16'h0000);
    rd_chk("code", `BDGR_ADDR_CODE, 16'h0000);
    rd_chk("active", `BDGR_ADDR_ACTIVE, 16'h0000);
    rd_chk("pin_a", `BDGR_ADDR_PIN_A, 16'h0008);
    chk("pulldown", 16'h0001, {15'h0000, pd});
    chk("pin drive", 16'h0000, {15'h0000, pin_oe});
    $display("test reset done");
  endtask
  task automatic t_burnout;
    logic [2:0] cc;
    logic [1:0] pe;
    logic [15:0] w;
    for (int c = 0; c < 8; c++) begin
      cc = c[2:0];
      pe = {cc[0], ~cc[0]};
      w = {1'b1, cc, pe, cc, ~pe, cc, pe};
      wr(`BDGR_ADDR_BURNOUT, w);
      rd_chk("burnout", `BDGR_ADDR_BURNOUT, w & 16'h7fff);
      chk("sense2 level", lvl(cc, 1'b0), 16'(lv_2));
      chk("sense1 level", lvl(cc, 1'b0), 16'(lv_1));
      chk("terminal level", lvl(cc, 1'b1), 16'(lv_t));
      chk("pol en", {10'h000, pe, ~pe, pe}, {10'h000, s2p, s2e, s1p, s1e, tp, te});
    end
    $display("test burnout done");
  endtask
  task automatic t_code;
    wr(`BDGR_ADDR_CODE, 16'hffff);
    rd_chk("code", `BDGR_ADDR_CODE, 16'h3fff);
    chk("converter", 16'h3fff, {2'b00, code_o});
    wr(`BDGR_ADDR_ACTIVE, 16'h0000);
    rd_chk("active", `BDGR_ADDR_ACTIVE, 16'h3fff);
    rd_chk("unmapped", 7'h7f, 16'h0000);
    $display("test code done");
  endtask
  task automatic t_slew;
    logic [13:0] e;
    logic [13:0] prev;
    logic [13:0] tgt;
    int steps;
    @(negedge clk_sys_i);
    slew_enable_i = 1'b1;
    slew_step_i = 14'h1000;
    e = 14'h3fff;
    // walk down first, then up, so both step directions are seen
    for (int r = 0; r < 2; r++) begin
      tgt = (r == 0) ? 14'h0010 : 14'h2010;
      prev = code_o;
      steps = 0;
      fork
        wr(`BDGR_ADDR_CODE, {2'b00, tgt});
        begin
          for (int k = 0; k < 1000 && e != tgt; k++) begin
            @(negedge clk_sys_i);
            if (code_o !== prev) begin
              if (e > tgt) begin
                e = (e - tgt > 14'h1000) ? e - 14'h1000 : tgt;
              end else begin
                e = (tgt - e > 14'h1000) ? e + 14'h1000 : tgt;
              end
              chk("slew step", {2'b00, e}, {2'b00, code_o});
              prev = code_o;
              steps++;
            end
          end
          if (e != tgt) begin
            num_errors++;
            end_sim();
          end
        end
      join
      chk("slew steps", (r == 0) ? 16'h0004 : 16'h0002, steps[15:0]);
    end
    @(negedge clk_sys_i) slew_enable_i = 1'b0;
    rd_chk("code kept", `BDGR_ADDR_CODE, 16'h2010);
    rd_chk("active", `BDGR_ADDR_ACTIVE, 16'h2010);
    $display("test slew done");
  endtask
  task automatic pin_case(input logic [2:0] m, input logic l, input logic x, input logic cm);
    logic drv;
    logic rb;
    @(negedge clk_sys_i);
    ext_lvl = x;
    comparator_i = cm;
    wr(`BDGR_ADDR_PIN_A, {10'h3ff, 1'b1, l, 1'b0, m});
    drv = (m == 3'h1 || m == 3'h2 || m == 3'h4);
    rb = (m == 3'h2) ? l : ((m == 3'h3) ? x : 1'b0);
    chk("pin drive", {15'h0000, drv}, {15'h0000, pin_oe});
    chk("pin out", {15'h0000, drv & (m == 3'h4 ? cm : l)}, {15'h0000, drv & pin_o});
    rd_chk("pin_a", `BDGR_ADDR_PIN_A, {10'h000, rb, l, 1'b0, m});
    chk("pulldown", 16'h0000, {15'h0000, pd});
  endtask
  initial begin
    rst_i = 1'b1;
    slew_enable_i = 1'b0;
    slew_step_i = 14'h0001;
    comparator_i = 1'b0;
    ext_lvl = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    t_reset();
    t_burnout();
    t_code();
    t_slew();
    pin_case(3'h0, 1'b1, 1'b1, 1'b1);
    pin_case(3'h1, 1'b1, 1'b0, 1'b0);
    pin_case(3'h1, 1'b0, 1'b1, 1'b1);
    pin_case(3'h2, 1'b1, 1'b0, 1'b0);
    pin_case(3'h2, 1'b0, 1'b1, 1'b0);
    pin_case(3'h3, 1'b0, 1'b1, 1'b0);
    pin_case(3'h3, 1'b1, 1'b0, 1'b1);
    pin_case(3'h4, 1'b0, 1'b0, 1'b1);
    pin_case(3'h4, 1'b1, 1'b1, 1'b0);
    pin_case(3'h7, 1'b1, 1'b1, 1'b1);
    $display("test pin done");
    end_sim();
  end
endmodule // bdgr_regs_tb_top
